/* include/adsel_regs.svh */
// register index, reset values and block table constants for the decimation and processing selector
`ifndef ADSEL_REGS_SVH
`define ADSEL_REGS_SVH
`define ADSEL_SEL_PAGE 8'h00
`define ADSEL_SEL_REG 8'h3D
`define ADSEL_BLK_RESET 5'h01
`define ADSEL_BLK_MAX 5'h12
`define ADSEL_FIR_LONG 5'h19
`define ADSEL_FIR_SHORT 5'h14
`define ADSEL_BQ_A 3'h5
`define ADSEL_BQ_B 3'h3
`define ADSEL_OSR_128 8'h80
`define ADSEL_OSR_64 8'h40
`define ADSEL_OSR_32 8'h20
`define ADSEL_COEF_MIN 16'h8000
`define ADSEL_COEF_MAX 16'h7FFF
`define ADSEL_NCOEF 7'h40
`define ADSEL_FIFO_DEPTH 16
`endif

/* include/adsel_pkg.sv */
// types for the decimation and processing selector
package adsel_pkg;
	typedef enum logic [1:0] {ADSEL_DEC_A = 2'b00, ADSEL_DEC_B = 2'b01, ADSEL_DEC_C = 2'b10} adsel_dec_t;
	typedef struct packed {
		logic stereo;
		adsel_dec_t dec;
		logic iir;
		logic [2:0] biquads;
		logic [4:0] fir_taps;
		logic osr128_ok;
		logic [7:0] osr_req;
		logic [7:0] instr_count;
	} adsel_cfg_t;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} adsel_sample_t;
endpackage

/* rtl/adsel_top.sv */
// processing block selector with configuration decode and output sample fifo
`timescale 1ns/1ps
`default_nettype none
`include "adsel_regs.svh"

// output sample fifo, parameterised width and depth
module adsel_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} adsel_fifo_st_t;
	adsel_fifo_st_t st_r, st_nxt;
	logic push, pop;
	// full and empty both come from the held count
	assign in_ready_out = (st_r.cnt != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid_out = (st_r.cnt != '0);
	assign out_data_out = mem[st_r.rp];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	// pointer and count update
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.wp = st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = st_r.rp + 1'b1;
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// storage has no reset; unwritten words show on out_data_out only while out_valid_out is low
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[st_r.wp] <= in_data_in;
		end
	end
endmodule

// Operation
// - decimate modulator data to nyquist rate with filter a, b or c
// - each block fixes both processing stages and decimation filter
// - software writes block choice at page 0 register 61
// - after reset block 1: stereo, filter a, iir, no biquads, no fir
// - iir, biquad and fir coefficients are fully programmable
// - every block has first-order iir then agc compensation
// - stereo blocks 1-3,7-9,14,15; others right channel only
// - blocks 2,5 five biquads filter a; 14,17 five biquads filter c
// - blocks 8,11 three biquads with filter b
// - blocks 3,6 25-tap fir filter a; 15,18 25-tap fir filter c
// - blocks 9,12 20-tap fir filter b; 1,4,7,10,13,16 plain
// - oversampling 128/64 for a, 64 for b, 32 for c; fixed instruction counts
// - coefficients are 16-bit 1.15 two's complement in two 8-bit registers
module adsel_top
	import adsel_pkg::*;
#(
	parameter int DEPTH = `ADSEL_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// control register write port
	input wire logic wr_en_in,
	input wire logic [7:0] wr_page_in,
	input wire logic [7:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] adc_oversampling_ratio_in,
	input wire logic adc_powered_in,
	// coefficient write port
	input wire logic coef_wr_in,
	input wire logic [6:0] coef_idx_in,
	input wire logic [15:0] coef_in,
	// decimated samples from the filter core
	input wire logic samp_valid_in,
	output logic samp_ready_out,
	input wire adsel_sample_t samp_in,
	// configuration status
	output adsel_cfg_t cfg_out,
	output logic [4:0] processing_block_choice_out,
	output logic [7:0] instruction_count_out,
	output logic cfg_error_out,
	// chosen coefficient readback
	output logic [15:0] coef_rd_out,
	// output sample stream
	output logic out_valid_out,
	input wire logic out_ready_in,
	output adsel_sample_t out_data_out
);
	localparam int OW = $clog2(DEPTH) + 1;
	typedef struct packed {
		logic [4:0] blk;
		adsel_cfg_t cfg;
		logic err;
		logic [15:0] rd;
		logic [OW-1:0] occ;
		logic rdy;
		logic ov;
		adsel_sample_t od;
	} adsel_st_t;
	adsel_st_t st_r, st_nxt;
	logic [15:0] coef_mem [`ADSEL_NCOEF];
	logic f_valid, f_ready, f_push;
	adsel_sample_t f_data, masked;

	// block table: channel set, filter, stages, oversampling and instruction count
	function automatic adsel_cfg_t decode(input logic [4:0] b);
		adsel_cfg_t c;
		c = '0;
		c.iir = 1'b1;
		unique case (b)
			5'h01: c = '{1'b1, ADSEL_DEC_A, 1'b1, 3'h0, 5'h00, 1'b1, `ADSEL_OSR_64, 8'd188};
			5'h02: c = '{1'b1, ADSEL_DEC_A, 1'b1, `ADSEL_BQ_A, 5'h00, 1'b1, `ADSEL_OSR_64, 8'd240};
			5'h03: c = '{1'b1, ADSEL_DEC_A, 1'b1, 3'h0, `ADSEL_FIR_LONG, 1'b1, `ADSEL_OSR_64, 8'd236};
			5'h04: c = '{1'b0, ADSEL_DEC_A, 1'b1, 3'h0, 5'h00, 1'b1, `ADSEL_OSR_64, 8'd96};
			5'h05: c = '{1'b0, ADSEL_DEC_A, 1'b1, `ADSEL_BQ_A, 5'h00, 1'b1, `ADSEL_OSR_64, 8'd120};
			5'h06: c = '{1'b0, ADSEL_DEC_A, 1'b1, 3'h0, `ADSEL_FIR_LONG, 1'b1, `ADSEL_OSR_64, 8'd120};
			5'h07: c = '{1'b1, ADSEL_DEC_B, 1'b1, 3'h0, 5'h00, 1'b0, `ADSEL_OSR_64, 8'd88};
			5'h08: c = '{1'b1, ADSEL_DEC_B, 1'b1, `ADSEL_BQ_B, 5'h00, 1'b0, `ADSEL_OSR_64, 8'd120};
			5'h09: c = '{1'b1, ADSEL_DEC_B, 1'b1, 3'h0, `ADSEL_FIR_SHORT, 1'b0, `ADSEL_OSR_64, 8'd128};
			5'h0A: c = '{1'b0, ADSEL_DEC_B, 1'b1, 3'h0, 5'h00, 1'b0, `ADSEL_OSR_64, 8'd46};
			5'h0B: c = '{1'b0, ADSEL_DEC_B, 1'b1, `ADSEL_BQ_B, 5'h00, 1'b0, `ADSEL_OSR_64, 8'd60};
			5'h0C: c = '{1'b0, ADSEL_DEC_B, 1'b1, 3'h0, `ADSEL_FIR_SHORT, 1'b0, `ADSEL_OSR_64, 8'd64};
			5'h0D: c = '{1'b0, ADSEL_DEC_C, 1'b1, 3'h0, 5'h00, 1'b0, `ADSEL_OSR_32, 8'd70};
			5'h0E: c = '{1'b1, ADSEL_DEC_C, 1'b1, `ADSEL_BQ_A, 5'h00, 1'b0, `ADSEL_OSR_32, 8'd124};
			5'h0F: c = '{1'b1, ADSEL_DEC_C, 1'b1, 3'h0, `ADSEL_FIR_LONG, 1'b0, `ADSEL_OSR_32, 8'd120};
			5'h10: c = '{1'b0, ADSEL_DEC_C, 1'b1, 3'h0, 5'h00, 1'b0, `ADSEL_OSR_32, 8'd36};
			5'h11: c = '{1'b0, ADSEL_DEC_C, 1'b1, `ADSEL_BQ_A, 5'h00, 1'b0, `ADSEL_OSR_32, 8'd64};
			5'h12: c = '{1'b0, ADSEL_DEC_C, 1'b1, 3'h0, `ADSEL_FIR_LONG, 1'b0, `ADSEL_OSR_32, 8'd62};
			default: c = '{1'b1, ADSEL_DEC_A, 1'b1, 3'h0, 5'h00, 1'b1, `ADSEL_OSR_64, 8'd188};
		endcase
		return c;
	endfunction

	// right-only blocks zero the left lane so a mono stream never carries stale data
	always_comb begin
		masked = samp_in;
		if (!st_r.cfg.stereo) begin
			masked.left = 16'h0000;
		end
	end

	adsel_fifo #(
		.WIDTH($bits(adsel_sample_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.in_valid_in(f_push),
		.in_ready_out(),
		.in_data_in(masked),
		.out_valid_out(f_valid),
		.out_ready_in(f_ready),
		.out_data_out(f_data)
	);

	// output skid register drains the fifo when empty or taken
	assign f_ready = !st_r.ov || out_ready_in;
	// push only on the ready we showed, so source and fifo agree on every word
	assign f_push = samp_valid_in && st_r.rdy;

	// coefficient store, raw 1.15 words, software fully programs them
	always_ff @(posedge clock_in) begin
		if (coef_wr_in) begin
			coef_mem[coef_idx_in[5:0]] <= coef_in;
		end
	end

	// next state: selection write, decode, error check, stream stage
	always_comb begin
		st_nxt = st_r;
		// a write outside the valid range or while powered is ignored
		if (wr_en_in && wr_page_in == `ADSEL_SEL_PAGE && wr_addr_in == `ADSEL_SEL_REG
				&& !adc_powered_in && wr_data_in[4:0] != 5'h00
				&& wr_data_in[4:0] <= `ADSEL_BLK_MAX && wr_data_in[7:5] == 3'h0) begin
			st_nxt.blk = wr_data_in[4:0];
		end
		st_nxt.cfg = decode(st_nxt.blk);
		// flag an oversampling ratio the chosen filter cannot run with
		st_nxt.err = !(adc_oversampling_ratio_in == st_nxt.cfg.osr_req
			|| (st_nxt.cfg.osr128_ok && adc_oversampling_ratio_in == `ADSEL_OSR_128));
		st_nxt.rd = coef_mem[coef_idx_in[5:0]];
		// own occupancy copy; registered ready must already cover next cycle's push
		if (f_push && !(f_valid && f_ready)) begin
			st_nxt.occ = st_r.occ + 1'b1;
		end else if (!f_push && f_valid && f_ready) begin
			st_nxt.occ = st_r.occ - 1'b1;
		end
		st_nxt.rdy = (st_nxt.occ != OW'(DEPTH));
		if (f_ready) begin
			st_nxt.ov = f_valid;
			st_nxt.od = f_data;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			st_r.blk <= `ADSEL_BLK_RESET;
			st_r.cfg <= '{1'b1, ADSEL_DEC_A, 1'b1, 3'h0, 5'h00, 1'b1, `ADSEL_OSR_64, 8'd188};
			st_r.err <= 1'b0;
			st_r.rd <= 16'h0000;
			st_r.occ <= '0;
			st_r.rdy <= 1'b0;
			st_r.ov <= 1'b0;
			st_r.od <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// all outputs straight from the state register
	assign cfg_out = st_r.cfg;
	assign processing_block_choice_out = st_r.blk;
	assign instruction_count_out = st_r.cfg.instr_count;
	assign cfg_error_out = st_r.err;
	assign coef_rd_out = st_r.rd;
	assign samp_ready_out = st_r.rdy;
	assign out_valid_out = st_r.ov;
	assign out_data_out = st_r.od;
endmodule
`default_nettype wire

/* verif/adsel_chk.sv */
// port-level checks for the processing block selector
`timescale 1ns/1ps
`default_nettype none
module adsel_chk import adsel_pkg::*; (
	// clock, reset and select write
	input wire logic clock_in, rst_in, wr_en_in, adc_powered_in,
	input wire logic [7:0] wr_page_in, wr_addr_in, wr_data_in, adc_oversampling_ratio_in,
	// configuration status
	input wire adsel_cfg_t cfg_out,
	input wire logic [4:0] processing_block_choice_out,
	input wire logic [7:0] instruction_count_out,
	input wire logic cfg_error_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	logic ok_w;
	logic [4:0] b;
	// a legal write: right page, index, powered down, number in range
	assign ok_w = wr_en_in && wr_page_in == 8'h00 && wr_addr_in == 8'h3D && !adc_powered_in && wr_data_in inside {[1:18]};
	assign b = processing_block_choice_out;
	AST_TAKE: assert property (ok_w |=> b == $past(wr_data_in[4:0])) else $error("select write not taken");
	AST_HOLD: assert property (!ok_w |=> $stable(b)) else $error("block changed without legal write");
	AST_INSTR: assert property (instruction_count_out == cfg_out.instr_count) else $error("count mismatch");
	AST_STEREO: assert property (cfg_out.stereo == (b inside {1, 2, 3, 7, 8, 9, 14, 15})) else $error("channel set");
	AST_DEC: assert property (cfg_out.dec == (b < 7 ? ADSEL_DEC_A : b < 13 ? ADSEL_DEC_B : ADSEL_DEC_C)) else $error("filter");
	AST_IIR: assert property (cfg_out.iir) else $error("iir stage missing");
	AST_BQ: assert property (cfg_out.biquads == (b inside {2, 5, 14, 17} ? 3'h5 : b inside {8, 11} ? 3'h3 : 3'h0))
		else $error("biquad count");
	AST_FIR: assert property (cfg_out.fir_taps == (b inside {3, 6, 15, 18} ? 5'h19 : b inside {9, 12} ? 5'h14 : 5'h00))
		else $error("fir taps");
	// error flag lags ratio by a cycle, so only judged once both settle
	AST_ERR: assert property ($stable(adc_oversampling_ratio_in) && $stable(b) |-> cfg_error_out == !(cfg_out.dec == ADSEL_DEC_A ?
		adc_oversampling_ratio_in inside {8'h80, 8'h40} : adc_oversampling_ratio_in == (cfg_out.dec == ADSEL_DEC_B ? 8'h40 : 8'h20)))
		else $error("ratio flag");
	cover property (ok_w);
	cover property (cfg_error_out);
	cover property (!cfg_out.stereo);
endmodule
`default_nettype wire

/* verif/adsel_src.sv */
// filter core stand-in feeding numbered samples
`timescale 1ns/1ps
`default_nettype none
module adsel_src import adsel_pkg::*; (
	input wire logic clock_in, rst_in, en_in, ready_in,
	output logic valid_out,
	output adsel_sample_t samp_out
);
	logic [15:0] n_r;
	// count moves only on acceptance, so data stands while stalled
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) n_r <= 16'h0000;
		else if (valid_out && ready_in) n_r <= n_r + 16'h0001;
	end
	assign valid_out = en_in;
	// idle lanes carry the inverse so stale data never matches
	assign samp_out = en_in ? {16'hA000 | n_r, n_r} : {~n_r, ~n_r};
endmodule
`default_nettype wire

/* verif/adc_decimation_processing_select_tb.sv */
// bench for the processing block selector
`timescale 1ns/1ps
`default_nettype none
module adc_decimation_processing_select_tb;
	import adsel_pkg::*;
	logic clock_in = 0, rst_in = 1, wr_en_in = 0, adc_powered_in = 0, coef_wr_in = 0, en = 0, out_ready_in = 0;
	logic [7:0] wr_page_in = 0, wr_addr_in = 0, wr_data_in = 0, adc_oversampling_ratio_in = 8'h40, instruction_count_out;
	logic [6:0] coef_idx_in = 0;
	logic [15:0] coef_in = 0, coef_rd_out;
	logic samp_valid_in, samp_ready_out, out_valid_out, cfg_error_out;
	logic [4:0] processing_block_choice_out;
	adsel_sample_t samp_in, out_data_out;
	adsel_cfg_t cfg_out;
	int num_errors = 0, check_count = 0, cyc = 0, rx = 0;
	int ic[18] = '{188, 240, 236, 96, 120, 120, 88, 120, 128, 46, 60, 64, 70, 124, 120, 36, 64, 62};
	int bq[18] = '{0, 5, 0, 0, 5, 0, 0, 3, 0, 0, 3, 0, 0, 5, 0, 0, 5, 0};
	int ft[18] = '{0, 0, 25, 0, 0, 25, 0, 0, 20, 0, 0, 20, 0, 0, 25, 0, 0, 25};
	adsel_top dut(.clock_in, .rst_in, .wr_en_in, .wr_page_in, .wr_addr_in, .wr_data_in, .adc_oversampling_ratio_in,
		.adc_powered_in, .coef_wr_in, .coef_idx_in, .coef_in, .samp_valid_in, .samp_ready_out, .samp_in, .cfg_out,
		.processing_block_choice_out, .instruction_count_out, .cfg_error_out, .coef_rd_out, .out_valid_out,
		.out_ready_in, .out_data_out);
	adsel_src src(.clock_in, .rst_in, .en_in(en), .ready_in(samp_ready_out), .valid_out(samp_valid_in), .samp_out(samp_in));
	initial forever #2.5 clock_in = ~clock_in;
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clock_in) if (++cyc == 20000) begin
		num_errors++;
		wrap_up;
	end
	task wrap_up;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] p, a, d);
		@(negedge clock_in);
		{wr_page_in, wr_addr_in, wr_data_in, wr_en_in} = {p, a, d, 1'b1};
		@(negedge clock_in) wr_en_in = 0;
	endtask
	task t_reset;
		rst_in = 1;
		repeat (5) @(negedge clock_in);
		rst_in = 0;
		@(negedge clock_in);
		chk(processing_block_choice_out, 1);
		chk({cfg_out.stereo, cfg_out.dec, cfg_out.biquads, cfg_out.fir_taps}, 11'h400);
		chk({instruction_count_out, cfg_error_out}, 376);
	endtask
	task t_table;
		for (int b = 1; b <= 18; b++) begin
			wr(8'h00, 8'h3D, b[7:0]);
			chk(processing_block_choice_out, b);
			chk(cfg_out.stereo, b inside {1, 2, 3, 7, 8, 9, 14, 15});
			chk(cfg_out.dec, (b - 1) / 6);
			chk(cfg_out.iir, 1);
			chk(cfg_out.biquads, bq[b-1]);
			chk(cfg_out.fir_taps, ft[b-1]);
			chk(instruction_count_out, ic[b-1]);
			for (int k = 0; k < 3; k++) begin
				adc_oversampling_ratio_in = 8'h80 >> k;
				repeat (2) @(negedge clock_in);
				chk(cfg_error_out, !((b - 1) / 6 == 0 ? k < 2 : (b - 1) / 6 == 1 ? k == 1 : k == 2));
			end
			adc_oversampling_ratio_in = 8'h40;
		end
	endtask
	task t_refuse;
		wr(8'h00, 8'h3D, 8'h05);
		adc_powered_in = 1;
		wr(8'h00, 8'h3D, 8'h07);
		adc_powered_in = 0;
		chk(processing_block_choice_out, 5);
		wr(8'h00, 8'h3D, 8'h00);
		wr(8'h00, 8'h3D, 8'h13);
		wr(8'h00, 8'h3E, 8'h07);
		wr(8'h01, 8'h3D, 8'h07);
		wr(8'h00, 8'h3D, 8'h27);
		chk(processing_block_choice_out, 5);
	endtask
	task t_coef;
		for (int i = 0; i < 2; i++) @(negedge clock_in) {coef_wr_in, coef_idx_in, coef_in} = {1'b1, 7'h03 + 7'(i), i ? 16'h7FFF : 16'h8000};
		@(negedge clock_in) coef_wr_in = 0;
		for (int i = 0; i < 2; i++) begin
			coef_idx_in = 7'h03 + 7'(i);
			@(negedge clock_in) chk(coef_rd_out, i ? 16'h7FFF : 16'h8000);
		end
	endtask
	task t_stream(input int b);
		wr(8'h00, 8'h3D, b[7:0]);
		en = 1;
		repeat (30) @(negedge clock_in);
		chk(samp_ready_out, 0);
		en = 0;
		out_ready_in = 1;
		repeat (40) begin
			if (out_valid_out) begin
				chk(out_data_out.right, rx);
				chk(out_data_out.left, b == 1 ? 16'hA000 | rx[15:0] : 16'h0000);
				rx++;
			end
			@(negedge clock_in);
		end
		@(negedge clock_in) out_ready_in = 0;
		chk(rx, src.n_r);
	endtask
	initial begin
		t_reset;
		t_table;
		t_reset;
		t_refuse;
		t_coef;
		t_stream(1);
		t_stream(4);
		wrap_up;
	end
endmodule
bind adsel_top adsel_chk chk_i(.clock_in, .rst_in, .wr_en_in, .adc_powered_in, .wr_page_in, .wr_addr_in, .wr_data_in,
	.adc_oversampling_ratio_in, .cfg_out, .processing_block_choice_out, .instruction_count_out, .cfg_error_out);
`default_nettype wire
